// ==== core/fcs_pkg.sv ====
// Shared constants and types for the floppy command sequencer.
// Assumes a 10 MHz controller clock and a host that writes command bytes one at a time.
package fcs_pkg;

	localparam int CLK_MHZ = 10;
	// One step-rate unit is 1 ms; the step period is (16 - step rate code) units.
	localparam int STEP_UNIT_US = 1000;
	localparam int STEP_UNIT_CYCLES = STEP_UNIT_US * CLK_MHZ;
	localparam logic [4:0] STEP_RATE_SPAN = 5'h10;
	localparam logic [7:0] RECAL_MAX_STEPS = 8'h50;

	// Opcode values; the write-deleted-data match ignores the two top mode bits.
	localparam logic [7:0] OP_MODE_MASK = 8'h3f;
	localparam logic [7:0] OP_WRITE_DELETED = 8'h09;
	localparam logic [7:0] OP_RECALIBRATE = 8'h07;
	localparam logic [7:0] OP_SENSE_INT = 8'h08;
	localparam logic [7:0] OP_SEEK = 8'h0f;
	localparam logic [7:0] OP_DUMP_REGS = 8'h0e;

	localparam logic [3:0] PARAMS_WRITE = 4'h8;
	localparam logic [3:0] PARAMS_SEEK = 4'h2;
	localparam logic [3:0] PARAMS_RECAL = 4'h1;

	// Parameter byte positions after the command byte.
	localparam int P_SEL = 0;
	localparam int P_CYL = 1;
	localparam int P_HEAD = 2;
	localparam int P_SECT = 3;
	localparam int P_SIZE = 4;
	localparam int P_FINAL = 5;
	localparam int P_GAP = 6;
	localparam int P_DLEN = 7;
	localparam int P_TARGET = 1;

	localparam logic [3:0] RES_WRITE = 4'h7;
	localparam logic [3:0] RES_SENSE = 4'h2;
	localparam logic [3:0] RES_DUMP = 4'ha;
	localparam logic [3:0] RES_SINGLE = 4'h1;

	localparam logic [7:0] STAT0_INVALID = 8'h80;
	localparam logic [1:0] STAT0_NORMAL = 2'h0;
	localparam logic [1:0] STAT0_ABNORMAL = 2'h1;
	localparam logic [15:0] SECTOR_BASE_BYTES = 16'h0080;

	typedef enum logic [2:0] {
		FCS_WRITE_DELETED,
		FCS_RECALIBRATE,
		FCS_SENSE_INT,
		FCS_SEEK,
		FCS_DUMP_REGS,
		FCS_INVALID
	} fcs_cmd_t;

	typedef enum logic [2:0] {
		FCS_IDLE,
		FCS_PARAM,
		FCS_EXEC_WRITE,
		FCS_EXEC_SEEK,
		FCS_RESULT
	} fcs_state_t;

endpackage

// ==== core/fcs_step_if.sv ====
// Link between the command sequencer and its head stepper.
// Assumes both ends share the controller clock.
`timescale 1ns/1ps
interface fcs_step_if;
	logic go;
	logic recal;
	logic [7:0] target;
	logic [7:0] start_cyl;
	logic [3:0] step_rate_time;
	logic done;
	logic fail;
	logic [7:0] end_cyl;
	logic step;
	logic dir;

	modport seq (output go, recal, target, start_cyl, step_rate_time,
		input done, fail, end_cyl, step, dir);
	modport stepper (input go, recal, target, start_cyl, step_rate_time,
		output done, fail, end_cyl, step, dir);
endinterface

// ==== core/fcs_stepper.sv ====
// Head stepper: walks the head to a target cylinder or out to track 0.
// Assumes track0_i is synchronous and high while the head sits on track 0.
`timescale 1ns/1ps
module fcs_stepper #(
	parameter int STEP_UNIT_CYCLES = fcs_pkg::STEP_UNIT_CYCLES
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic track0_i,
	fcs_step_if.stepper link
);

	typedef struct packed {
		logic busy;
		logic recal;
		logic [7:0] cur;
		logic [7:0] tgt;
		logic [19:0] timer;
		logic [7:0] nsteps;
		logic step;
		logic dir;
		logic done;
		logic fail;
	} fcs_step_state_t;

	fcs_step_state_t s;
	fcs_step_state_t next_s;
	logic [19:0] period;

	assign period = 20'(int'(fcs_pkg::STEP_RATE_SPAN - {1'b0, link.step_rate_time})
		* STEP_UNIT_CYCLES);

	always_comb begin
		next_s = s;
		next_s.step = 1'b0;
		next_s.done = 1'b0;
		if (!s.busy) begin
			if (link.go) begin
				next_s.busy = 1'b1;
				next_s.recal = link.recal;
				next_s.cur = link.start_cyl;
				next_s.tgt = link.target;
				next_s.timer = period;
				next_s.nsteps = 8'h00;
				next_s.fail = 1'b0;
			end
		end else if (s.timer != 20'h00000) begin
			next_s.timer = s.timer - 20'h00001;
		end else if (s.recal) begin
			if (track0_i) begin
				next_s.done = 1'b1;
				next_s.busy = 1'b0;
				next_s.cur = 8'h00;
			end else if (s.nsteps == fcs_pkg::RECAL_MAX_STEPS) begin
				next_s.done = 1'b1;
				next_s.fail = 1'b1;
				next_s.busy = 1'b0;
			end else begin
				next_s.step = 1'b1;
				next_s.dir = 1'b0;
				next_s.nsteps = s.nsteps + 8'h01;
				next_s.timer = period;
			end
		end else if (s.cur == s.tgt) begin
			next_s.done = 1'b1;
			next_s.busy = 1'b0;
		end else begin
			next_s.step = 1'b1;
			next_s.dir = (s.tgt > s.cur);
			next_s.cur = (s.tgt > s.cur) ? s.cur + 8'h01 : s.cur - 8'h01;
			next_s.timer = period;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign link.done = s.done;
	assign link.fail = s.fail;
	assign link.end_cyl = s.cur;
	assign link.step = s.step;
	assign link.dir = s.dir;

endmodule

// ==== core/fcs_top.sv ====
// Command-phase sequencer for write deleted data, recalibrate, sense interrupt,
// seek and register dump. Assumes the host writes and reads the data port one byte
// per strobe and that configuration fields arrive as stable inputs.
//
// Overview of operation
// - During execution sector bytes flow from the system out to the drive.
// - Write deleted data ends with three status bytes then cylinder, head, sector, size.
// - Recalibrate steps outward until track 0 or 80 steps, then interrupts; no result bytes.
// - Sense interrupt returns status zero and present cylinder of the last seek, or one byte 80h if no interrupt is pending.
// - Seek takes select and target cylinder, steps there, no result bytes.
// - Register dump returns four cylinders, timings, final sector, lock and config fields.
// - Unknown command does nothing and returns one status byte 80h.
`timescale 1ns/1ps
module fcs_top #(
	parameter int STEP_UNIT_CYCLES = fcs_pkg::STEP_UNIT_CYCLES
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic fifo_wr_i,
	input wire logic [7:0] fifo_wdata_i,
	input wire logic fifo_rd_i,
	output logic [7:0] fifo_rdata_o,
	output logic result_valid_o,
	output logic cmd_busy_o,
	output logic irq_o,
	input wire logic sys_valid_i,
	input wire logic [7:0] sys_data_i,
	output logic sys_req_o,
	output logic [7:0] disk_wdata_o,
	output logic disk_wr_o,
	output logic step_o,
	output logic dir_o,
	output logic [1:0] drive_select_o,
	output logic head_select_o,
	input wire logic track0_i,
	input wire logic [3:0] step_rate_time_i,
	input wire logic [3:0] head_unload_time_i,
	input wire logic [6:0] head_load_time_i,
	input wire logic non_dma_flag_i,
	input wire logic lock_i,
	input wire logic [3:0] perp_drive_i,
	input wire logic perp_gap_i,
	input wire logic perp_write_gate_i,
	input wire logic implied_seek_enable_i,
	input wire logic fifo_disable_bit_i,
	input wire logic poll_disable_i,
	input wire logic [3:0] fifo_threshold_i,
	input wire logic [7:0] precomp_start_track_i
);

	typedef struct packed {
		fcs_pkg::fcs_state_t state;
		fcs_pkg::fcs_cmd_t cmd;
		logic [3:0] pidx;
		logic [3:0] need;
		logic [7:0][7:0] prm;
		logic [9:0][7:0] res;
		logic [3:0] rcnt;
		logic [3:0] ridx;
		logic [3:0][7:0] cyl;
		logic [7:0] final_sector;
		logic [7:0] sector;
		logic [15:0] bytecnt;
		logic [7:0] seek_stat0;
		logic [1:0] seek_drive;
		logic irq;
		logic go;
		logic recal;
		logic [7:0] target;
		logic [7:0] rdata;
		logic rvalid;
		logic busy;
		logic sys_req;
		logic [7:0] disk_wdata;
		logic disk_wr;
		logic step;
		logic dir;
		logic [1:0] drive;
		logic head;
	} fcs_state_rec_t;

	fcs_state_rec_t s;
	fcs_state_rec_t next_s;
	fcs_step_if step_link ();

	function automatic fcs_pkg::fcs_cmd_t fcs_decode(input logic [7:0] op);
		if ((op & fcs_pkg::OP_MODE_MASK) == fcs_pkg::OP_WRITE_DELETED) begin
			return fcs_pkg::FCS_WRITE_DELETED;
		end else if (op == fcs_pkg::OP_RECALIBRATE) begin
			return fcs_pkg::FCS_RECALIBRATE;
		end else if (op == fcs_pkg::OP_SENSE_INT) begin
			return fcs_pkg::FCS_SENSE_INT;
		end else if (op == fcs_pkg::OP_SEEK) begin
			return fcs_pkg::FCS_SEEK;
		end else if (op == fcs_pkg::OP_DUMP_REGS) begin
			return fcs_pkg::FCS_DUMP_REGS;
		end else begin
			return fcs_pkg::FCS_INVALID;
		end
	endfunction

	// A size code of zero means the data length byte gives the sector length.
	function automatic logic [15:0] fcs_sector_bytes(input logic [7:0] code,
		input logic [7:0] dlen);
		if (code == 8'h00) begin
			return {8'h00, dlen};
		end else begin
			return fcs_pkg::SECTOR_BASE_BYTES << code[2:0];
		end
	endfunction

	function automatic logic [7:0] fcs_stat0(input logic [1:0] code, input logic seek_end,
		input logic fault, input logic hd, input logic [1:0] ds);
		return {code, seek_end, fault, 1'b0, hd, ds};
	endfunction

	assign step_link.go = s.go;
	assign step_link.recal = s.recal;
	assign step_link.target = s.target;
	assign step_link.start_cyl = s.cyl[s.drive];
	assign step_link.step_rate_time = step_rate_time_i;

	fcs_stepper #(
		.STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)
	) u_stepper (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.track0_i(track0_i),
		.link(step_link.stepper)
	);

	always_comb begin
		next_s = s;
		next_s.go = 1'b0;
		next_s.disk_wr = 1'b0;
		case (s.state)
			fcs_pkg::FCS_IDLE: begin
				if (fifo_wr_i) begin
					next_s.cmd = fcs_decode(fifo_wdata_i);
					next_s.pidx = 4'h0;
					next_s.ridx = 4'h0;
					case (fcs_decode(fifo_wdata_i))
						fcs_pkg::FCS_WRITE_DELETED: begin
							next_s.need = fcs_pkg::PARAMS_WRITE;
							next_s.state = fcs_pkg::FCS_PARAM;
						end
						fcs_pkg::FCS_SEEK: begin
							next_s.need = fcs_pkg::PARAMS_SEEK;
							next_s.state = fcs_pkg::FCS_PARAM;
						end
						fcs_pkg::FCS_RECALIBRATE: begin
							next_s.need = fcs_pkg::PARAMS_RECAL;
							next_s.state = fcs_pkg::FCS_PARAM;
						end
						fcs_pkg::FCS_SENSE_INT: begin
							if (s.irq) begin
								next_s.res[0] = s.seek_stat0;
								next_s.res[1] = s.cyl[s.seek_drive];
								next_s.rcnt = fcs_pkg::RES_SENSE;
								next_s.irq = 1'b0;
							end else begin
								next_s.res[0] = fcs_pkg::STAT0_INVALID;
								next_s.rcnt = fcs_pkg::RES_SINGLE;
							end
							next_s.state = fcs_pkg::FCS_RESULT;
						end
						fcs_pkg::FCS_DUMP_REGS: begin
							next_s.res[0] = s.cyl[0];
							next_s.res[1] = s.cyl[1];
							next_s.res[2] = s.cyl[2];
							next_s.res[3] = s.cyl[3];
							next_s.res[4] = {step_rate_time_i, head_unload_time_i};
							next_s.res[5] = {head_load_time_i, non_dma_flag_i};
							next_s.res[6] = s.final_sector;
							next_s.res[7] = {lock_i, 1'b0, perp_drive_i, perp_gap_i,
								perp_write_gate_i};
							next_s.res[8] = {1'b0, implied_seek_enable_i, fifo_disable_bit_i,
								poll_disable_i, fifo_threshold_i};
							next_s.res[9] = precomp_start_track_i;
							next_s.rcnt = fcs_pkg::RES_DUMP;
							next_s.state = fcs_pkg::FCS_RESULT;
						end
						default: begin
							next_s.res[0] = fcs_pkg::STAT0_INVALID;
							next_s.rcnt = fcs_pkg::RES_SINGLE;
							next_s.state = fcs_pkg::FCS_RESULT;
						end
					endcase
				end
			end
			fcs_pkg::FCS_PARAM: begin
				if (fifo_wr_i) begin
					next_s.prm[s.pidx[2:0]] = fifo_wdata_i;
					next_s.pidx = s.pidx + 4'h1;
					if (s.pidx == 4'h0) begin
						next_s.drive = fifo_wdata_i[1:0];
						next_s.head = fifo_wdata_i[2];
					end
					if (s.pidx == s.need - 4'h1) begin
						if (s.cmd == fcs_pkg::FCS_WRITE_DELETED) begin
							next_s.sector = s.prm[fcs_pkg::P_SECT];
							next_s.final_sector = s.prm[fcs_pkg::P_FINAL];
							next_s.bytecnt = 16'h0000;
							next_s.state = fcs_pkg::FCS_EXEC_WRITE;
						end else begin
							next_s.recal = (s.cmd == fcs_pkg::FCS_RECALIBRATE);
							next_s.target = fifo_wdata_i;
							next_s.go = 1'b1;
							next_s.state = fcs_pkg::FCS_EXEC_SEEK;
						end
					end
				end
			end
			fcs_pkg::FCS_EXEC_WRITE: begin
				if (s.sys_req && sys_valid_i) begin
					next_s.disk_wdata = sys_data_i;
					next_s.disk_wr = 1'b1;
					if (s.bytecnt == fcs_sector_bytes(s.prm[fcs_pkg::P_SIZE],
						s.prm[fcs_pkg::P_DLEN]) - 16'h0001) begin
						next_s.bytecnt = 16'h0000;
						if (s.sector >= s.final_sector) begin
							next_s.res[0] = fcs_stat0(fcs_pkg::STAT0_NORMAL, 1'b0, 1'b0,
								s.head, s.drive);
							next_s.res[1] = 8'h00;
							next_s.res[2] = 8'h00;
							next_s.res[3] = s.prm[fcs_pkg::P_CYL];
							next_s.res[4] = s.prm[fcs_pkg::P_HEAD];
							next_s.res[5] = s.sector;
							next_s.res[6] = s.prm[fcs_pkg::P_SIZE];
							next_s.rcnt = fcs_pkg::RES_WRITE;
							next_s.state = fcs_pkg::FCS_RESULT;
						end else begin
							next_s.sector = s.sector + 8'h01;
						end
					end else begin
						next_s.bytecnt = s.bytecnt + 16'h0001;
					end
				end
			end
			fcs_pkg::FCS_EXEC_SEEK: begin
				if (step_link.done) begin
					next_s.cyl[s.drive] = step_link.end_cyl;
					next_s.seek_drive = s.drive;
					next_s.seek_stat0 = fcs_stat0(step_link.fail ? fcs_pkg::STAT0_ABNORMAL :
						fcs_pkg::STAT0_NORMAL, 1'b1, step_link.fail, s.head, s.drive);
					next_s.irq = 1'b1;
					next_s.state = fcs_pkg::FCS_IDLE;
				end
			end
			fcs_pkg::FCS_RESULT: begin
				if (fifo_rd_i) begin
					if (s.ridx == s.rcnt - 4'h1) begin
						next_s.ridx = 4'h0;
						next_s.state = fcs_pkg::FCS_IDLE;
					end else begin
						next_s.ridx = s.ridx + 4'h1;
					end
				end
			end
			default: begin
				next_s.state = fcs_pkg::FCS_IDLE;
			end
		endcase
		next_s.rdata = next_s.res[next_s.ridx];
		next_s.rvalid = (next_s.state == fcs_pkg::FCS_RESULT);
		next_s.busy = (next_s.state != fcs_pkg::FCS_IDLE);
		next_s.sys_req = (next_s.state == fcs_pkg::FCS_EXEC_WRITE);
		next_s.step = step_link.step;
		next_s.dir = step_link.dir;
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign fifo_rdata_o = s.rdata;
	assign result_valid_o = s.rvalid;
	assign cmd_busy_o = s.busy;
	assign irq_o = s.irq;
	assign sys_req_o = s.sys_req;
	assign disk_wdata_o = s.disk_wdata;
	assign disk_wr_o = s.disk_wr;
	assign step_o = s.step;
	assign dir_o = s.dir;
	assign drive_select_o = s.drive;
	assign head_select_o = s.head;

endmodule

// ==== tb/fcs_host_model.sv ====
// Host processor model: writes command bytes and reads result bytes.
// Assumes each task is entered just after a rising clock edge.
`timescale 1ns/1ps
module fcs_host_model (
	input wire logic clock_i,
	output logic fifo_wr_o,
	output logic [7:0] fifo_wdata_o,
	output logic fifo_rd_o,
	input wire logic [7:0] fifo_rdata_i
);
	initial begin
		fifo_wr_o = 1'b0;
		fifo_wdata_o = 8'h00;
		fifo_rd_o = 1'b0;
	end
	// The released data bus shows the inverse so a stale byte is never taken.
	task automatic write_byte(input logic [7:0] b);
		fifo_wdata_o = b;
		fifo_wr_o = 1'b1;
		@(posedge clock_i);
		#1;
		fifo_wr_o = 1'b0;
		fifo_wdata_o = ~b;
		@(posedge clock_i);
		#1;
	endtask
	task automatic read_byte(output logic [7:0] b);
		b = fifo_rdata_i;
		fifo_rd_o = 1'b1;
		@(posedge clock_i);
		#1;
		fifo_rd_o = 1'b0;
		@(posedge clock_i);
		#1;
	endtask
endmodule

// ==== tb/fcs_monitor.sv ====
// Checker for the command sequencer, bound to its top module.
// Assumes it sees the top module's ports and shares its clock and reset.
`timescale 1ns/1ps
module fcs_monitor #(
	parameter int STEP_UNIT_CYCLES = fcs_pkg::STEP_UNIT_CYCLES
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic fifo_wr_i,
	input wire logic [7:0] fifo_wdata_i,
	input wire logic [7:0] fifo_rdata_o,
	input wire logic result_valid_o,
	input wire logic cmd_busy_o,
	input wire logic irq_o,
	input wire logic sys_valid_i,
	input wire logic [7:0] sys_data_i,
	input wire logic sys_req_o,
	input wire logic [7:0] disk_wdata_o,
	input wire logic disk_wr_o,
	input wire logic step_o
);
	logic known;
	logic take_q;
	assign known = ((fifo_wdata_i & fcs_pkg::OP_MODE_MASK) == fcs_pkg::OP_WRITE_DELETED)
		|| fifo_wdata_i == fcs_pkg::OP_RECALIBRATE || fifo_wdata_i == fcs_pkg::OP_SENSE_INT
		|| fifo_wdata_i == fcs_pkg::OP_SEEK || fifo_wdata_i == fcs_pkg::OP_DUMP_REGS;
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			take_q <= 1'b0;
		end else begin
			take_q <= sys_req_o && sys_valid_i;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	sequence s_new_cmd;
		fifo_wr_i && !cmd_busy_o;
	endsequence
	sequence s_take;
		sys_req_o && sys_valid_i;
	endsequence
	a_sense_clears_irq:
		assert property (s_new_cmd ##0 fifo_wdata_i == fcs_pkg::OP_SENSE_INT |=> !irq_o)
		else $error("irq not cleared by sense");
	a_sense_idle_status:
		assert property (s_new_cmd ##0 (fifo_wdata_i == fcs_pkg::OP_SENSE_INT && !irq_o)
			|=> result_valid_o && fifo_rdata_o == 8'h80) else $error("bad idle sense");
	a_invalid_status:
		assert property (s_new_cmd ##0 !known |=> result_valid_o && fifo_rdata_o == 8'h80)
		else $error("bad invalid status");
	a_dump_loads:
		assert property (s_new_cmd ##0 fifo_wdata_i == fcs_pkg::OP_DUMP_REGS |=> result_valid_o)
		else $error("dump gave no result");
	a_disk_follows:
		assert property (s_take |=> disk_wr_o && disk_wdata_o == $past(sys_data_i))
		else $error("sector byte not passed on");
	a_disk_caused:
		assert property (disk_wr_o |-> take_q) else $error("spurious disk write");
	a_step_pulse:
		assert property (step_o |=> !step_o) else $error("step pulse too long");
	a_move_end:
		assert property ($rose(irq_o) |-> !cmd_busy_o && !result_valid_o)
		else $error("irq without idle");
	a_result_busy:
		assert property (result_valid_o |-> cmd_busy_o) else $error("result while idle");
	a_req_exec:
		assert property (sys_req_o |-> cmd_busy_o && !result_valid_o)
		else $error("data request outside execution");
endmodule
bind fcs_top fcs_monitor #(.STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)) u_fcs_monitor (
	.clock_i(clock_i), .reset_i(reset_i), .fifo_wr_i(fifo_wr_i), .fifo_wdata_i(fifo_wdata_i),
	.fifo_rdata_o(fifo_rdata_o), .result_valid_o(result_valid_o), .cmd_busy_o(cmd_busy_o),
	.irq_o(irq_o), .sys_valid_i(sys_valid_i), .sys_data_i(sys_data_i), .sys_req_o(sys_req_o),
	.disk_wdata_o(disk_wdata_o), .disk_wr_o(disk_wr_o), .step_o(step_o));

// ==== tb/fcs_top_tb.sv ====
// Self-checking bench for the command sequencer.
// Assumes a 10 MHz clock and a shortened step unit of four cycles.
`timescale 1ns/1ps
module fcs_top_tb;
	localparam int UNIT = 4;
	logic clock_i, reset_i, wr, rd, rvalid, busy, irq, sys_valid, sys_req, disk_wr;
	logic step, dir, head, track0, last_dir;
	logic [7:0] wdata, rdata, sys_data, disk_wdata;
	logic [1:0] drive;
	logic [3:0] step_rate, unload_time, perp_drive, threshold;
	logic [6:0] load_time;
	logic no_dma, lock, perp_gap, perp_wg, seek_en, fifo_off, poll_off;
	logic [7:0] precomp;
	logic [7:0] disk_q [$];
	int steps, errors, comparisons;
	fcs_host_model u_fcs_host_model (.clock_i(clock_i), .fifo_wr_o(wr), .fifo_wdata_o(wdata),
		.fifo_rd_o(rd), .fifo_rdata_i(rdata));
	fcs_top #(.STEP_UNIT_CYCLES(UNIT)) u_fcs_top (.clock_i(clock_i), .reset_i(reset_i),
		.fifo_wr_i(wr), .fifo_wdata_i(wdata), .fifo_rd_i(rd), .fifo_rdata_o(rdata),
		.result_valid_o(rvalid), .cmd_busy_o(busy), .irq_o(irq), .sys_valid_i(sys_valid),
		.sys_data_i(sys_data), .sys_req_o(sys_req), .disk_wdata_o(disk_wdata),
		.disk_wr_o(disk_wr), .step_o(step), .dir_o(dir), .drive_select_o(drive),
		.head_select_o(head), .track0_i(track0), .step_rate_time_i(step_rate),
		.head_unload_time_i(unload_time), .head_load_time_i(load_time),
		.non_dma_flag_i(no_dma), .lock_i(lock), .perp_drive_i(perp_drive),
		.perp_gap_i(perp_gap), .perp_write_gate_i(perp_wg), .implied_seek_enable_i(seek_en),
		.fifo_disable_bit_i(fifo_off), .poll_disable_i(poll_off),
		.fifo_threshold_i(threshold), .precomp_start_track_i(precomp));
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		if (step) begin
			steps <= steps + 1;
			last_dir <= dir;
		end
		if (disk_wr) begin
			disk_q.push_back(disk_wdata);
		end
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic read_check(input string what, input logic [7:0] exp [$]);
		logic [7:0] b;
		foreach (exp[i]) begin
			check({what, " valid"}, {7'h00, rvalid}, 8'h01);
			u_fcs_host_model.read_byte(b);
			check(what, b, exp[i]);
		end
		check({what, " end"}, {7'h00, rvalid}, 8'h00);
	endtask
	task automatic wait_irq;
		for (int n = 0; n < 1000 && irq !== 1'b1; n++) begin
			@(posedge clock_i);
			#1;
		end
		check("irq", {7'h00, irq}, 8'h01);
	endtask
	task automatic t_status;
		u_fcs_host_model.write_byte(8'h1f);
		read_check("invalid", '{8'h80});
		u_fcs_host_model.write_byte(fcs_pkg::OP_SENSE_INT);
		read_check("idle sense", '{8'h80});
	endtask
	task automatic t_write;
		logic [7:0] p [$];
		p = '{8'hc9, 8'h06, 8'h12, 8'h01, 8'h05, 8'h00, 8'h05, 8'h1b, 8'h04};
		foreach (p[i]) u_fcs_host_model.write_byte(p[i]);
		for (int i = 0; i < 4; i++) begin
			check("sys req", {7'h00, sys_req}, 8'h01);
			sys_data = 8'h30 + 8'(i);
			sys_valid = 1'b1;
			@(posedge clock_i);
			#1;
			sys_valid = 1'b0;
			sys_data = ~sys_data;
			@(posedge clock_i);
			#1;
		end
		check("sys req end", {7'h00, sys_req}, 8'h00);
		check("disk count", 8'(disk_q.size()), 8'h04);
		check("write drive", {6'h00, drive}, 8'h02);
		check("write head", {7'h00, head}, 8'h01);
		foreach (disk_q[i]) check("disk byte", disk_q[i], 8'h30 + 8'(i));
		read_check("write result", '{8'h06, 8'h00, 8'h00, 8'h12, 8'h01, 8'h05, 8'h00});
	endtask
	task automatic t_seek;
		steps = 0;
		u_fcs_host_model.write_byte(fcs_pkg::OP_SEEK);
		u_fcs_host_model.write_byte(8'h01);
		u_fcs_host_model.write_byte(8'h03);
		wait_irq;
		check("seek steps", 8'(steps), 8'h03);
		check("seek dir", {7'h00, last_dir}, 8'h01);
		check("seek drive", {6'h00, drive}, 8'h01);
		check("seek head", {7'h00, head}, 8'h00);
		u_fcs_host_model.write_byte(fcs_pkg::OP_SENSE_INT);
		read_check("seek sense", '{8'h21, 8'h03});
		check("irq clear", {7'h00, irq}, 8'h00);
	endtask
	task automatic t_dump;
		u_fcs_host_model.write_byte(fcs_pkg::OP_DUMP_REGS);
		read_check("dump", '{8'h00, 8'h03, 8'h00, 8'h00, 8'hc5, 8'h55, 8'h05, 8'ha6,
			8'h57, 8'h3c});
	endtask
	task automatic t_recal;
		steps = 0;
		u_fcs_host_model.write_byte(fcs_pkg::OP_RECALIBRATE);
		u_fcs_host_model.write_byte(8'h01);
		for (int n = 0; n < 1000 && steps < 3; n++) begin
			@(posedge clock_i);
			#1;
		end
		track0 = 1'b1;
		wait_irq;
		check("recal steps", 8'(steps), 8'h03);
		check("recal dir", {7'h00, last_dir}, 8'h00);
		check("recal result", {7'h00, rvalid}, 8'h00);
		u_fcs_host_model.write_byte(fcs_pkg::OP_SENSE_INT);
		read_check("recal sense", '{8'h21, 8'h00});
	endtask
	// Without track 0 the head gives up after the step limit, at the fastest step rate.
	task automatic t_recal_fail;
		steps = 0;
		track0 = 1'b0;
		step_rate = 4'hf;
		u_fcs_host_model.write_byte(fcs_pkg::OP_RECALIBRATE);
		u_fcs_host_model.write_byte(8'h00);
		wait_irq;
		check("recal limit", 8'(steps), 8'h50);
		check("recal fail dir", {7'h00, last_dir}, 8'h00);
		u_fcs_host_model.write_byte(fcs_pkg::OP_SENSE_INT);
		read_check("recal fail sense", '{8'h70, 8'h00});
	endtask
	// Every configuration bit except the step rate takes the opposite value from the first dump.
	task automatic t_dump_alt;
		unload_time = 4'ha;
		load_time = 7'h55;
		no_dma = 1'b0;
		lock = 1'b0;
		perp_drive = 4'h6;
		perp_gap = 1'b0;
		perp_wg = 1'b1;
		seek_en = 1'b0;
		fifo_off = 1'b1;
		poll_off = 1'b0;
		threshold = 4'h8;
		precomp = 8'hc3;
		u_fcs_host_model.write_byte(fcs_pkg::OP_DUMP_REGS);
		read_check("dump alt", '{8'h00, 8'h00, 8'h00, 8'h00, 8'hfa, 8'haa, 8'h05, 8'h19,
			8'h28, 8'hc3});
	endtask
	task automatic end_sim;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		errors++;
		end_sim;
	end
	initial begin
		reset_i = 1'b1;
		sys_valid = 1'b0;
		sys_data = 8'h00;
		track0 = 1'b0;
		step_rate = 4'hc;
		unload_time = 4'h5;
		load_time = 7'h2a;
		no_dma = 1'b1;
		lock = 1'b1;
		perp_drive = 4'h9;
		perp_gap = 1'b1;
		perp_wg = 1'b0;
		seek_en = 1'b1;
		fifo_off = 1'b0;
		poll_off = 1'b1;
		threshold = 4'h7;
		precomp = 8'h3c;
		steps = 0;
		last_dir = 1'b0;
		errors = 0;
		comparisons = 0;
		repeat (20) @(posedge clock_i);
		#1;
		reset_i = 1'b0;
		t_status;
		t_write;
		t_seek;
		t_dump;
		t_recal;
		t_recal_fail;
		t_dump_alt;
		end_sim;
	end
endmodule
